// ===== rtl/usb_serial_uart_bridge.v
// usb virtual serial port to target serial link bridge, frame buffered
// assumes usb side and file parser present bytes synchronous to i_ref_clk
`timescale 1ns/1ps
`include "uart_bridge_defines.vh"
// What this block does
// - requested speed clamped into 1200 bps .. 500 kbps.
// - speed may change while data flows; applied at each bit.
// - characters always carry eight data bits.
// - parity odd, even or none, chosen by host.
// - one or two stop bits, chosen by host.
// - only transmit and receive lines, no handshake pins.
// - setup readable before session; data paths idle without terminal ready.
// - terminal ready enables level shifters and both data paths.
// - on terminal ready drop, stop receiving, drain queue, refuse host data.
// - after drain completes, shifters off, transmit line floats.
// - transmit line undriven until host enables the interface or an override starts.
// - send-text file content goes out on transmit line.
// - override handles a 512-byte frame with 498 payload characters.
// - override ends at first zero character.
// - generic send-text uses 9600 bps.
// - explicit send-text speeds limited to 9600, 115200, 460800.
// - active session suspended during override, resumed after.
// - host data queued as up to four 64-byte frames, throttled when full.
// - target bytes packed into 64-byte frames, handed over when full.
// - partial receive frames flushed about every 100 ms of start-of-frame.
// - at most eight receive frames outstanding.
// - on overrun the last filled frame is reused and discarded.
module usb_serial_uart_bridge #(
  parameter FLUSH_SOFS = `FLUSH_MS * `SOF_PER_MS
) (
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  // line setup from host
  input  wire [31:0] i_baud_req,
  input  wire [1:0]  i_parity,
  input  wire        i_two_stop,
  input  wire        i_dtr,
  input  wire        i_sof,
  // host to target bytes
  input  wire        i_h2t_valid,
  input  wire [7:0]  i_h2t_data,
  input  wire        i_h2t_last,
  output reg         o_h2t_ready,
  // target to host frames
  output reg         o_t2h_valid,
  output reg  [7:0]  o_t2h_data,
  output reg         o_t2h_last,
  input  wire        i_t2h_ready,
  // send-text override from file parser
  input  wire        i_ovr_start,
  input  wire [1:0]  i_ovr_speed,
  input  wire        i_ovr_valid,
  input  wire [7:0]  i_ovr_data,
  output reg         o_ovr_ready,
  output reg         o_ovr_busy,
  // status
  output reg  [31:0] o_baud_eff,
  output reg         o_rx_overrun,
  output reg         o_rx_err,
  // target link pins
  output reg         o_bridge_transmit_line,
  output reg         o_bridge_transmit_line_oe_n,
  input  wire        i_bridge_receive_line
);
  localparam TXD = `TX_FRAMES * `TX_FRAME_BYTES;
  localparam RXD = `RX_FRAMES * `RX_FRAME_BYTES;
  localparam [8:0] OVR_N = `OVR_PAYLOAD;

  function [15:0] div_of;
    input [31:0] b;
    reg   [31:0] q;
    begin
      q = `CLK_HZ / b;
      div_of = q[15:0];
    end
  endfunction

  // =======================================================
  // session control
  reg  [31:0] baud_r;
  reg         sess_r;
  reg         drain_r;
  reg         ovr_r;
  reg         ovr_end_r;
  reg  [8:0]  ovr_cnt_r;
  reg  [15:0] ovr_div_r;
  reg  [1:0]  rxs1_r;
  wire [15:0] div_w;
  wire        tx_ready;
  wire        tx_line;
  wire        tx_busy;
  wire        rx_valid;
  wire [7:0]  rx_data;
  wire        rx_err;

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      baud_r <= `BAUD_MIN; o_baud_eff <= `BAUD_MIN;
    end else begin
      // clamped silently; readable before any session
      if (i_baud_req < `BAUD_MIN) baud_r <= `BAUD_MIN;
      else if (i_baud_req > `BAUD_MAX) baud_r <= `BAUD_MAX;
      else baud_r <= i_baud_req;
      o_baud_eff <= baud_r;
    end
  end

  // =======================================================
  // host to target queue: four 64-byte frames
  reg [7:0] tq_mem [0:TXD-1];
  reg [8:0] tq_wr_r;
  reg [8:0] tq_rd_r;
  reg [8:0] tq_fill_r;
  reg [2:0] tq_frames_r;
  wire      tq_empty = (tq_wr_r == tq_rd_r);
  wire      tq_pop;
  wire      frame_room = (tq_frames_r < `TX_FRAMES);
  wire      h2t_take = i_h2t_valid && o_h2t_ready;
  wire      tq_flen_done = h2t_take && (i_h2t_last || tq_fill_r == `TX_FRAME_BYTES - 1);

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      tq_wr_r <= 9'h000; tq_fill_r <= 9'h000; o_h2t_ready <= 1'b0;
    end else begin
      // refused when no session, draining, override, or four frames held
      o_h2t_ready <= sess_r && !ovr_r && frame_room && !(tq_flen_done && tq_frames_r == 3'h3) &&
        ((tq_wr_r - tq_rd_r) < TXD - 1);
      if (h2t_take) begin
        tq_mem[tq_wr_r[7:0]] <= i_h2t_data;
        tq_wr_r <= tq_wr_r + 9'h001;
        tq_fill_r <= tq_flen_done ? 9'h000 : tq_fill_r + 9'h001;
      end
    end
  end

  // frame accounting: one frame per 64 bytes or short final
  reg [8:0] tq_done_r;
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      tq_frames_r <= 3'h0; tq_done_r <= 9'h000;
    end else begin
      if (tq_pop) tq_done_r <= tq_done_r + 9'h001;
      // frame released once its bytes are sent; approximated as 64-byte chunks
      if (tq_flen_done && !(tq_pop && tq_done_r[5:0] == 6'h3f))
        tq_frames_r <= tq_frames_r + 3'h1;
      else if (!tq_flen_done && tq_pop && (tq_done_r[5:0] == 6'h3f || tq_rd_r + 9'h001 == tq_wr_r)
               && tq_frames_r != 3'h0)
        tq_frames_r <= tq_frames_r - 3'h1;
    end
  end

  // =======================================================
  // transmitter source select and line driver
  wire       use_ovr = ovr_r;
  wire       tx_valid = use_ovr ? (i_ovr_valid && i_ovr_data != 8'h00 && ovr_cnt_r != 9'h000)
                                : (!tq_empty && (sess_r || drain_r));
  wire [7:0] tx_data = use_ovr ? i_ovr_data : tq_mem[tq_rd_r[7:0]];
  assign tq_pop = tx_ready && !use_ovr;
  assign div_w = use_ovr ? ovr_div_r : div_of(baud_r);

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      tq_rd_r <= 9'h000;
    end else if (tq_pop) begin
      tq_rd_r <= tq_rd_r + 9'h001;
    end
  end

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sess_r <= 1'b0; drain_r <= 1'b0; ovr_r <= 1'b0; ovr_cnt_r <= 9'h000;
      ovr_end_r <= 1'b0;
      ovr_div_r <= 16'h0000; o_ovr_busy <= 1'b0; o_ovr_ready <= 1'b0;
      o_bridge_transmit_line <= 1'b1; o_bridge_transmit_line_oe_n <= 1'b1;
    end else begin
      o_ovr_ready <= 1'b0;
      if (i_ovr_start && !ovr_r) begin
        ovr_r <= 1'b1; o_ovr_busy <= 1'b1;
        ovr_cnt_r <= OVR_N;
        case (i_ovr_speed)
          `OVR_SEL_115200: ovr_div_r <= div_of(`BAUD_OVR_MID);
          `OVR_SEL_460800: ovr_div_r <= div_of(`BAUD_OVR_HI);
          default:         ovr_div_r <= div_of(`BAUD_OVR_DEF);
        endcase
      end else if (ovr_r) begin
        if (tx_ready) begin
          o_ovr_ready <= 1'b1; ovr_cnt_r <= ovr_cnt_r - 9'h001;
        end
        // zero char or payload exhausted marks the end; busy falls a cycle
        // later at the earliest, so the accept pulse never lands outside busy
        if (!ovr_end_r && ((i_ovr_valid && i_ovr_data == 8'h00 && !o_ovr_ready) ||
            ovr_cnt_r == 9'h000)) begin
          ovr_end_r <= 1'b1;
          if (i_ovr_data == 8'h00 && i_ovr_valid && !o_ovr_ready) o_ovr_ready <= 1'b1;
        end
        if (ovr_end_r && !tx_busy && !tx_ready) begin
          ovr_r <= 1'b0; o_ovr_busy <= 1'b0; ovr_end_r <= 1'b0;
        end
      end
      if (i_dtr) begin
        sess_r <= 1'b1; drain_r <= 1'b0;
      end else if (sess_r) begin
        sess_r <= 1'b0; drain_r <= 1'b1;
      end else if (drain_r && tq_empty && !tx_busy && !tx_ready) begin
        drain_r <= 1'b0;
      end
      // line driven while session, drain or override holds it
      o_bridge_transmit_line_oe_n <= !(sess_r || drain_r || ovr_r);
      o_bridge_transmit_line <= tx_line;
    end
  end

  uart_bit_engine u_engine (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_div      (div_w),
    .i_parity   (use_ovr ? `PAR_NONE : i_parity),
    .i_two_stop (use_ovr ? 1'b0 : i_two_stop),
    .i_tx_valid (tx_valid),
    .i_tx_data  (tx_data),
    .o_tx_ready (tx_ready),
    .o_tx_line  (tx_line),
    .o_tx_busy  (tx_busy),
    .i_rx_en    (sess_r && !ovr_r),
    .i_rx_line  (rxs1_r[1]),
    .o_rx_valid (rx_valid),
    .o_rx_data  (rx_data),
    .o_rx_err   (rx_err)
  );

  // =======================================================
  // target to host: eight 64-byte frames
  reg [7:0] rq_mem [0:RXD-1];
  reg [2:0] rf_wr_r;
  reg [5:0] rf_fill_r;
  reg [2:0] rf_rd_r;
  reg [5:0] rf_pos_r;
  reg [3:0] rf_cnt_r;
  reg [6:0] rf_len_r [0:`RX_FRAMES-1];
  reg [15:0] sof_cnt_r;
  wire      full_now = rx_valid && rf_fill_r == 6'h3f;
  wire      flush = (sof_cnt_r >= FLUSH_SOFS - 1) && i_sof && rf_fill_r != 6'h00 && !full_now;
  wire      commit = full_now || flush;
  wire      send_done = o_t2h_valid && i_t2h_ready && o_t2h_last;
  wire      can_commit = (rf_cnt_r < `RX_FRAMES) || send_done;

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rxs1_r <= 2'h3; rf_wr_r <= 3'h0; rf_fill_r <= 6'h00; rf_cnt_r <= 4'h0;
      sof_cnt_r <= 16'h0000; o_rx_overrun <= 1'b0; o_rx_err <= 1'b0;
    end else begin
      rxs1_r <= {rxs1_r[0], i_bridge_receive_line};
      o_rx_err <= rx_err;
      o_rx_overrun <= 1'b0;
      if (i_sof) sof_cnt_r <= commit ? 16'h0000 : sof_cnt_r + 16'h0001;
      if (rx_valid) begin
        rq_mem[{rf_wr_r, rf_fill_r}] <= rx_data;
        rf_fill_r <= rf_fill_r + 6'h01;
      end
      if (commit) begin
        if (can_commit) begin
          rf_len_r[rf_wr_r] <= full_now ? 7'h40 : {1'b0, rf_fill_r};
          rf_wr_r <= rf_wr_r + 3'h1;
        end else o_rx_overrun <= 1'b1;
        if (flush) rf_fill_r <= 6'h00;
        sof_cnt_r <= 16'h0000;
      end
      rf_cnt_r <= rf_cnt_r + ((commit && can_commit) ? 4'h1 : 4'h0) - (send_done ? 4'h1 : 4'h0);
    end
  end

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rf_rd_r <= 3'h0; rf_pos_r <= 6'h00;
      o_t2h_valid <= 1'b0; o_t2h_data <= 8'h00; o_t2h_last <= 1'b0;
    end else if (!o_t2h_valid || i_t2h_ready) begin
      o_t2h_valid <= 1'b0; o_t2h_last <= 1'b0;
      if (send_done) begin
        rf_rd_r <= rf_rd_r + 3'h1; rf_pos_r <= 6'h00;
      end else if (rf_cnt_r != 4'h0) begin
        o_t2h_valid <= 1'b1;
        o_t2h_data <= rq_mem[{rf_rd_r, rf_pos_r}];
        o_t2h_last <= ({1'b0, rf_pos_r} == rf_len_r[rf_rd_r] - 7'h01);
        rf_pos_r <= rf_pos_r + 6'h01;
      end
    end
  end
endmodule

// ===== rtl/uart_bridge_defines.vh
// constants for the serial bridge: line limits, override speeds, frame sizes
// assumes a 40 MHz reference clock; figures are in their own units
`ifndef UART_BRIDGE_DEFINES_VH
`define UART_BRIDGE_DEFINES_VH
`define CLK_HZ          40000000
`define BAUD_MIN        1200
`define BAUD_MAX        500000
`define BAUD_OVR_DEF    9600
`define BAUD_OVR_MID    115200
`define BAUD_OVR_HI     460800
`define DIV_OF(b)       (`CLK_HZ / (b))
`define TX_FRAME_BYTES  64
`define TX_FRAMES       4
`define RX_FRAME_BYTES  64
`define RX_FRAMES       8
`define OVR_PAYLOAD     498
`define FLUSH_MS        100
`define SOF_PER_MS      1
`define PAR_NONE        2'h0
`define PAR_ODD         2'h1
`define PAR_EVEN        2'h2
`define OVR_SEL_DEF     2'h0
`define OVR_SEL_9600    2'h1
`define OVR_SEL_115200  2'h2
`define OVR_SEL_460800  2'h3
`endif

// ===== rtl/uart_bit_engine.v
// serial character transmitter and receiver sharing one bit-period divisor
// assumes rx line already synchronised by the parent; divisor >= 16
`timescale 1ns/1ps
`include "uart_bridge_defines.vh"
module uart_bit_engine (
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  // line setup
  input  wire [15:0] i_div,
  input  wire [1:0]  i_parity,
  input  wire        i_two_stop,
  // transmit side
  input  wire        i_tx_valid,
  input  wire [7:0]  i_tx_data,
  output reg         o_tx_ready,
  output reg         o_tx_line,
  output reg         o_tx_busy,
  // receive side
  input  wire        i_rx_en,
  input  wire        i_rx_line,
  output reg         o_rx_valid,
  output reg  [7:0]  o_rx_data,
  output reg         o_rx_err
);
  localparam S_IDLE = 3'h0;
  localparam S_START = 3'h1;
  localparam S_DATA = 3'h2;
  localparam S_PAR = 3'h3;
  localparam S_STOP = 3'h4;

  function par_bit;
    input [7:0] d;
    input [1:0] mode;
    begin
      par_bit = (mode == `PAR_ODD) ? ~(^d) : (^d);
    end
  endfunction

  // =======================================================
  // transmitter
  reg [2:0]  ts_r;
  reg [15:0] tcnt_r;
  reg [2:0]  tbit_r;
  reg [7:0]  tsh_r;
  reg [1:0]  tpar_r;
  reg        tstop2_r;
  reg        tstopn_r;
  wire       ttick = (tcnt_r == 16'h0000);

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ts_r <= S_IDLE; tcnt_r <= 16'h0000; tbit_r <= 3'h0; tsh_r <= 8'h00;
      tpar_r <= 2'h0; tstop2_r <= 1'b0; tstopn_r <= 1'b0;
      o_tx_line <= 1'b1; o_tx_busy <= 1'b0; o_tx_ready <= 1'b0;
    end else begin
      o_tx_ready <= 1'b0;
      if (!ttick) tcnt_r <= tcnt_r - 16'h0001;
      case (ts_r)
        S_IDLE: begin
          o_tx_line <= 1'b1;
          o_tx_busy <= 1'b0;
          if (i_tx_valid && !o_tx_ready) begin
            // parity and stop count latched per character; divisor reread each bit so speed may change live
            o_tx_ready <= 1'b1; tsh_r <= i_tx_data; tpar_r <= i_parity;
            tstop2_r <= i_two_stop; o_tx_busy <= 1'b1;
            o_tx_line <= 1'b0; tcnt_r <= i_div - 16'h0001; ts_r <= S_START;
          end
        end
        S_START: if (ttick) begin
          o_tx_line <= tsh_r[0]; tbit_r <= 3'h0; tcnt_r <= i_div - 16'h0001; ts_r <= S_DATA;
        end
        S_DATA: if (ttick) begin
          tcnt_r <= i_div - 16'h0001;
          if (tbit_r == 3'h7) begin
            if (tpar_r != `PAR_NONE) begin
              o_tx_line <= par_bit(tsh_r, tpar_r); ts_r <= S_PAR;
            end else begin
              o_tx_line <= 1'b1; tstopn_r <= tstop2_r; ts_r <= S_STOP;
            end
          end else begin
            o_tx_line <= tsh_r[tbit_r + 3'h1]; tbit_r <= tbit_r + 3'h1;
          end
        end
        S_PAR: if (ttick) begin
          o_tx_line <= 1'b1; tstopn_r <= tstop2_r; tcnt_r <= i_div - 16'h0001; ts_r <= S_STOP;
        end
        S_STOP: if (ttick) begin
          tcnt_r <= i_div - 16'h0001;
          if (tstopn_r) tstopn_r <= 1'b0;
          else ts_r <= S_IDLE;
        end
        default: ts_r <= S_IDLE;
      endcase
    end
  end

  // =======================================================
  // receiver, samples mid-bit
  reg [2:0]  rs_r;
  reg [15:0] rcnt_r;
  reg [2:0]  rbit_r;
  reg [7:0]  rsh_r;
  wire       rtick = (rcnt_r == 16'h0000);

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rs_r <= S_IDLE; rcnt_r <= 16'h0000; rbit_r <= 3'h0; rsh_r <= 8'h00;
      o_rx_valid <= 1'b0; o_rx_data <= 8'h00; o_rx_err <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      o_rx_err <= 1'b0;
      if (!rtick) rcnt_r <= rcnt_r - 16'h0001;
      case (rs_r)
        S_IDLE: if (i_rx_en && !i_rx_line) begin
          rcnt_r <= {1'b0, i_div[15:1]}; rs_r <= S_START;
        end
        S_START: if (rtick) begin
          if (i_rx_line) rs_r <= S_IDLE;
          else begin
            rcnt_r <= i_div - 16'h0001; rbit_r <= 3'h0; rs_r <= S_DATA;
          end
        end
        S_DATA: if (rtick) begin
          rsh_r <= {i_rx_line, rsh_r[7:1]}; rcnt_r <= i_div - 16'h0001;
          if (rbit_r == 3'h7) rs_r <= (i_parity != `PAR_NONE) ? S_PAR : S_STOP;
          else rbit_r <= rbit_r + 3'h1;
        end
        S_PAR: if (rtick) begin
          o_rx_err <= (i_rx_line != par_bit(rsh_r, i_parity));
          rcnt_r <= i_div - 16'h0001; rs_r <= S_STOP;
        end
        S_STOP: if (rtick) begin
          if (i_rx_line) begin
            o_rx_valid <= i_rx_en; o_rx_data <= rsh_r;
          end else o_rx_err <= 1'b1;
          rs_r <= S_IDLE;
        end
        default: rs_r <= S_IDLE;
      endcase
    end
  end
endmodule

// ===== verif/tgt_uart_model.sv
// target serial port model: decodes the bridge output, sends bytes back
// assumes the bench sets bit period and format before each character
`timescale 1ns/1ps
module tgt_uart_model (
  // clock
  input  wire        i_clk,
  // bridge side of the link
  input  wire        i_line,
  input  wire        i_oe_n,
  input  wire [15:0] i_bit,
  input  wire [1:0]  i_par,
  input  wire        i_two,
  output reg         o_line
);
  // pull-up on our pin: a floating line reads idle, not a start bit
  wire       rx_w = i_oe_n ? 1'b1 : i_line;
  reg  [7:0] d;
  reg        p;
  reg        stop_ok;
  integer    n_got;
  integer    i;
  task wait_bits(input integer n);
    repeat (n * i_bit) @(posedge i_clk);
  endtask
  initial begin
    o_line = 1'b1;
    n_got = 0;
  end
  // ==========================================
  // receive, sampled mid bit
  always begin
    @(negedge rx_w);
    repeat (i_bit / 2) @(posedge i_clk);
    if (!rx_w) begin
      for (i = 0; i < 8; i = i + 1) begin
        wait_bits(1);
        d[i] = rx_w;
      end
      if (i_par != 2'h0) begin
        wait_bits(1);
        p = rx_w;
      end
      wait_bits(1);
      stop_ok = rx_w;
      if (i_two) begin
        wait_bits(1);
        stop_ok = stop_ok & rx_w;
      end
      n_got = n_got + 1;
    end
  end
  // frame is {stop, data, start}, sent lsb first
  task send(input [9:0] f);
    integer k;
    for (k = 0; k < 10; k = k + 1) begin
      @(posedge i_clk);
      o_line <= f[k];
      repeat (i_bit - 1) @(posedge i_clk);
    end
  endtask
endmodule

// ===== verif/usb_serial_uart_bridge_chk.sv
// assertion checker for the serial bridge, bound to its top module
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/1ps
`include "uart_bridge_defines.vh"
module usb_serial_uart_bridge_chk #(
  parameter FLUSH_SOFS = 100
) (
  // clock and reset
  input wire        i_ref_clk,
  input wire        i_rst_n,
  // watched ports
  input wire [31:0] i_baud_req,
  input wire        i_dtr,
  input wire        o_h2t_ready,
  input wire        o_t2h_valid,
  input wire [7:0]  o_t2h_data,
  input wire        o_t2h_last,
  input wire        i_t2h_ready,
  input wire        o_ovr_ready,
  input wire        o_ovr_busy,
  input wire [31:0] o_baud_eff,
  input wire        o_bridge_transmit_line,
  input wire        o_bridge_transmit_line_oe_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire [31:0] clamp_w = (i_baud_req < `BAUD_MIN) ? `BAUD_MIN :
                        (i_baud_req > `BAUD_MAX) ? `BAUD_MAX : i_baud_req;
  // ==========================================
  // assertions
  AST_RST_FLOAT: assert property (disable iff (1'b0) !i_rst_n |=> o_bridge_transmit_line_oe_n)
    else $error("transmit line driven after reset");
  AST_BAUD_CLAMP: assert property ($stable(i_baud_req) [*4] |-> o_baud_eff == clamp_w)
    else $error("effective speed not the clamped request");
  AST_IDLE_NO_DATA: assert property (!i_dtr [*4] |-> !o_h2t_ready)
    else $error("host data accepted without terminal ready");
  AST_OVR_HOLD: assert property (o_ovr_busy [*4] |-> !o_h2t_ready)
    else $error("host data accepted during override");
  AST_DTR_READY: assert property ($rose(i_dtr) && !o_ovr_busy |-> ##[1:4] o_h2t_ready)
    else $error("session did not open");
  AST_DTR_OE: assert property ($rose(i_dtr) |-> ##[1:4] !o_bridge_transmit_line_oe_n)
    else $error("line not driven after terminal ready");
  AST_FLOAT_AFTER: assert property ($rose(o_bridge_transmit_line_oe_n) |-> !i_dtr
    && $past(o_bridge_transmit_line) && $past(o_bridge_transmit_line, 2))
    else $error("line released mid character or with session open");
  AST_T2H_HOLD: assert property (o_t2h_valid && !i_t2h_ready |=> o_t2h_valid
    && $stable(o_t2h_data) && $stable(o_t2h_last))
    else $error("frame byte changed while stalled");
  AST_OVR_PULSE: assert property (o_ovr_ready |-> o_ovr_busy ##1 !o_ovr_ready)
    else $error("override accept outside override");
  // ==========================================
  // covers
  COV_DTR: cover property ($rose(i_dtr));
  COV_OVR: cover property ($fell(o_ovr_busy));
  COV_T2H: cover property (o_t2h_valid && i_t2h_ready && o_t2h_last);
endmodule
bind usb_serial_uart_bridge usb_serial_uart_bridge_chk #(.FLUSH_SOFS(FLUSH_SOFS)) i_chk (.*);

// ===== verif/tb.sv
// self-checking bench for the serial bridge with a target port model
// assumes 40 MHz clock; flush count shortened to keep the run brief
`timescale 1ns/1ps
`include "uart_bridge_defines.vh"
`define CHK(a, b) begin n_tests = n_tests + 1; if ((a) !== (b)) begin \
  n_mismatch = n_mismatch + 1; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
`define WAITN(c, lim) begin k = 0; while ((c) !== 1'b1 && k < lim) begin \
  @(negedge i_ref_clk); k = k + 1; end if ((c) !== 1'b1) begin n_mismatch = n_mismatch + 1; \
  $display("unexpected at %0t: wait ran out %h %h", $time, 1'b0, 1'b1); report_and_stop; end end
module tb;
  // ==========================================
  // stimulus and wires
  reg         i_ref_clk   = 1'b0;
  reg         i_rst_n     = 1'b0;
  reg  [31:0] i_baud_req  = 32'h0;
  reg  [1:0]  i_parity    = 2'h0;
  reg         i_two_stop  = 1'b0;
  reg         i_dtr       = 1'b0;
  reg         i_sof       = 1'b0;
  reg         i_h2t_valid = 1'b0;
  reg  [7:0]  i_h2t_data  = 8'h0;
  reg         i_h2t_last  = 1'b1;
  reg         i_t2h_ready = 1'b0;
  reg         i_ovr_start = 1'b0;
  reg  [1:0]  i_ovr_speed = 2'h0;
  reg         i_ovr_valid = 1'b0;
  reg  [7:0]  i_ovr_data  = 8'h0;
  reg  [15:0] bit_cyc     = 16'h50;
  wire        o_h2t_ready, o_t2h_valid, o_t2h_last, o_ovr_ready, o_ovr_busy;
  wire        o_rx_overrun, o_rx_err, o_bridge_transmit_line, o_bridge_transmit_line_oe_n;
  wire [7:0]  o_t2h_data;
  wire [31:0] o_baud_eff;
  wire        i_bridge_receive_line;
  integer     n_mismatch, n_tests, k, m, n0;
  integer     n_rx_err = 0;
  integer     n_rx_ovr = 0;
  always @(posedge i_ref_clk) begin
    if (o_rx_err === 1'b1) n_rx_err <= n_rx_err + 1;
    if (o_rx_overrun === 1'b1) n_rx_ovr <= n_rx_ovr + 1;
  end
  reg  [7:0]  d;
  always #12.5 i_ref_clk = ~i_ref_clk;
  usb_serial_uart_bridge #(.FLUSH_SOFS(3)) i_dut (.*);
  tgt_uart_model u_tgt (.i_clk(i_ref_clk), .i_line(o_bridge_transmit_line),
    .i_oe_n(o_bridge_transmit_line_oe_n), .i_bit(bit_cyc), .i_par(i_parity),
    .i_two(i_two_stop), .o_line(i_bridge_receive_line));
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one byte on the host path (sel 0) or the override path (sel 1)
  task put(input sel, input [7:0] b);
    @(posedge i_ref_clk);
    if (sel) begin
      i_ovr_valid <= 1'b1;
      i_ovr_data <= b;
    end else begin
      i_h2t_valid <= 1'b1;
      i_h2t_data <= b;
    end
    @(negedge i_ref_clk);
    `WAITN((sel ? o_ovr_ready : o_h2t_ready), 60000)
    @(posedge i_ref_clk);
    i_ovr_valid <= 1'b0;
    i_h2t_valid <= 1'b0;
  endtask
  task sofs;
    repeat (4) begin
      @(posedge i_ref_clk);
      i_sof <= 1'b1;
      @(posedge i_ref_clk);
      i_sof <= 1'b0;
      repeat (5) @(posedge i_ref_clk);
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    repeat (2) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(negedge i_ref_clk);
    `CHK(o_bridge_transmit_line_oe_n, 1'b1)
    `CHK(o_h2t_ready, 1'b0)
    @(posedge i_ref_clk);
    i_baud_req <= 32'h64;
    repeat (6) @(negedge i_ref_clk);
    `CHK(o_baud_eff, `BAUD_MIN)
    @(posedge i_ref_clk);
    i_baud_req <= 32'h895440;
    repeat (6) @(negedge i_ref_clk);
    `CHK(o_baud_eff, `BAUD_MAX)
    `CHK(o_bridge_transmit_line_oe_n, 1'b1)
    @(posedge i_ref_clk);
    i_dtr <= 1'b1;
    @(negedge i_ref_clk);
    `WAITN(o_h2t_ready, 10)
    `CHK(o_bridge_transmit_line_oe_n, 1'b0)
    // every parity mode with one and two stop bits
    for (m = 0; m < 6; m = m + 1) begin
      @(posedge i_ref_clk);
      i_parity <= 2'(m % 3);
      i_two_stop <= 1'(m / 3);
      d = 8'h96 + 8'(m);
      n0 = u_tgt.n_got;
      put(1'b0, d);
      `WAITN(u_tgt.n_got == n0 + 1, 3000)
      `CHK(u_tgt.d, d)
      if (m % 3 != 0) `CHK(u_tgt.p, (m % 3 == 1) ? ~^d : ^d)
      `CHK(u_tgt.stop_ok, 1'b1)
      repeat (200) @(posedge i_ref_clk);
    end
    i_parity <= 2'h0;
    i_two_stop <= 1'b0;
    // partial receive frame waits for start-of-frame pacing
    u_tgt.send({1'b1, 8'h3c, 1'b0});
    repeat (200) @(negedge i_ref_clk);
    `CHK(o_t2h_valid, 1'b0)
    sofs();
    `WAITN(o_t2h_valid, 100)
    `CHK(o_t2h_data, 8'h3c)
    `CHK(o_t2h_last, 1'b1)
    @(posedge i_ref_clk);
    i_t2h_ready <= 1'b1;
    @(posedge i_ref_clk);
    i_t2h_ready <= 1'b0;
    @(negedge i_ref_clk);
    `CHK(o_t2h_valid, 1'b0)
    // every override speed code; code 1 sends only the terminator
    for (m = 0; m < 4; m = m + 1) begin
      @(posedge i_ref_clk);
      i_ovr_speed <= 2'(m);
      i_ovr_start <= 1'b1;
      bit_cyc <= (m == 2) ? 16'(`DIV_OF(`BAUD_OVR_MID)) :
                 (m == 3) ? 16'(`DIV_OF(`BAUD_OVR_HI)) : 16'(`DIV_OF(`BAUD_OVR_DEF));
      @(posedge i_ref_clk);
      i_ovr_start <= 1'b0;
      n0 = u_tgt.n_got;
      if (m != 1) put(1'b1, 8'h40 + 8'(m));
      put(1'b1, 8'h00);
      `WAITN(o_ovr_busy === 1'b0, 50000)
      `CHK(u_tgt.n_got, n0 + ((m != 1) ? 1 : 0))
      if (m != 1) `CHK(u_tgt.d, 8'h40 + 8'(m))
      `WAITN(o_h2t_ready, 10)
    end
    // queued bytes drain after terminal ready drops, then the line floats
    bit_cyc <= 16'h50;
    n0 = u_tgt.n_got;
    for (m = 0; m < 3; m = m + 1) put(1'b0, 8'hc0 + 8'(m));
    i_dtr <= 1'b0;
    repeat (6) @(negedge i_ref_clk);
    `CHK(o_h2t_ready, 1'b0)
    `CHK(o_bridge_transmit_line_oe_n, 1'b0)
    `WAITN(o_bridge_transmit_line_oe_n, 5000)
    `CHK(u_tgt.n_got, n0 + 3)
    `CHK(u_tgt.d, 8'hc2)
    u_tgt.send({1'b1, 8'h77, 1'b0});
    sofs();
    `CHK(o_t2h_valid, 1'b0)
    `CHK(n_rx_err, 0)
    `CHK(n_rx_ovr, 0)
    report_and_stop;
  end
endmodule
